// file: pcm_gain_mute_and_event_logic.sv
// PCM gain, soft mute, word formatting, receive FIFO, events and AHB-Lite slave
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module pcm_gain_mute_and_event_logic
  import pcm_gain_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sample_valid,
  input wire logic sample_right,
  input wire logic [23:0] sample_data,
  input wire logic sample_period_tick,
  output logic converter_irq
);

  // ==========================================================================
  // Functions
  function automatic logic [8:0] code_to_target(input logic [3:0] code);
    logic [8:0] scaled;
    scaled = 9'(code) * CODE_STEP_X2;
    return TARGET_BASE + (scaled >> 1);
  endfunction : code_to_target

  // Piecewise-linear inside each octave: cheap, error under 0.6 dB
  function automatic logic [15:0] level_to_gain(input logic [8:0] lvl);
    logic [8:0] oct;
    logic [8:0] frac;
    logic [15:0] mant;
    oct = lvl / UNITS_PER_OCTAVE;
    frac = lvl - 9'(oct * UNITS_PER_OCTAVE);
    mant = MANT_ONE + ((16'(frac) * MANT_SLOPE_X16) >> 4);
    return mant << oct[2:0];
  endfunction : level_to_gain

  function automatic logic [8:0] step_toward(input logic [8:0] cur,
                                             input logic [8:0] tgt,
                                             input logic big);
    logic [8:0] d;
    logic [8:0] s;
    s = big ? 9'h002 : 9'h001;
    if (cur < tgt) begin
      d = tgt - cur;
      return (d < s) ? tgt : cur + s;
    end else begin
      d = cur - tgt;
      return (d < s) ? tgt : cur - s;
    end
  endfunction : step_toward

  // ==========================================================================
  // AHB-Lite slave: reads take one wait state so read data is registered
  logic dp_read_q;
  logic dp_write_q;
  logic [7:0] dp_addr_q;
  logic accept;
  logic wr_en;
  logic [31:0] rd_value;
  logic [31:0] hrdata_q;
  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = ~dp_read_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wr_en = dp_write_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_read_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      dp_read_q <= accept && !hwrite;
      dp_write_q <= accept && hwrite;
      if (accept) begin
        dp_addr_q <= haddr[7:0];
      end
    end
  end

  // ==========================================================================
  // Control registers
  logic [3:0] gain_left_q;
  logic [3:0] gain_right_q;
  logic fine_step_select_q;
  logic soft_mute_ctl_q;
  logic [1:0] step_interval_q;
  logic [1:0] sample_width_q;
  logic msb_fill_mode_q;
  logic [7:0] fifo_threshold_q;
  logic [EVT_COUNT-1:0] event_enable_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_left_q <= GAIN_RESET;
      gain_right_q <= GAIN_RESET;
      fine_step_select_q <= 1'b0;
      soft_mute_ctl_q <= 1'b0;
    end else if (wr_en && dp_addr_q == OFS_CONVERTER_CONTROL) begin
      // Taken at any time; the smoother absorbs the change
      gain_left_q <= hwdata[GAIN_LEFT_LSB+:4];
      gain_right_q <= hwdata[GAIN_RIGHT_LSB+:4];
      fine_step_select_q <= hwdata[FINE_STEP_BIT];
      soft_mute_ctl_q <= hwdata[SOFT_MUTE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_interval_q <= STEP_INTERVAL_RESET;
      sample_width_q <= SAMPLE_WIDTH_RESET;
      msb_fill_mode_q <= 1'b0;
      fifo_threshold_q <= THRESHOLD_RESET;
      event_enable_q <= 4'h0;
    end else if (wr_en) begin
      case (dp_addr_q)
        OFS_MODE_CONTROL: step_interval_q <= hwdata[STEP_INTERVAL_LSB+:2];
        OFS_DATA_FORMAT: begin
          sample_width_q <= hwdata[SAMPLE_WIDTH_LSB+:2];
          msb_fill_mode_q <= hwdata[MSB_FILL_BIT];
        end
        OFS_FIFO_CONTROL: fifo_threshold_q <= hwdata[THRESHOLD_LSB+:8];
        OFS_EVENT_ENABLE: begin
          event_enable_q <= hwdata[EVT_COUNT-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Smoother: both channels step together on the interval pulse
  logic [9:0] interval_cnt_q;
  logic [9:0] interval_len;
  logic step_en;
  logic [8:0] level_left_q;
  logic [8:0] level_right_q;
  logic [8:0] target_left;
  logic [8:0] target_right;
  assign interval_len = INTERVAL_BASE << step_interval_q;
  assign step_en = sample_period_tick &&
                   (interval_cnt_q >= interval_len - 10'h001);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interval_cnt_q <= 10'h000;
    end else if (step_en) begin
      interval_cnt_q <= 10'h000;
    end else if (sample_period_tick) begin
      interval_cnt_q <= interval_cnt_q + 10'h001;
    end
  end

  // Mute targets the floor, unmute returns to the current codes
  assign target_left = soft_mute_ctl_q ? LEVEL_MUTE :
                       code_to_target(gain_left_q);
  assign target_right = soft_mute_ctl_q ? LEVEL_MUTE :
                        code_to_target(gain_right_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_left_q <= TARGET_BASE;
      level_right_q <= TARGET_BASE;
    end else if (step_en) begin
      level_left_q <= step_toward(level_left_q, target_left,
                                  fine_step_select_q);
      level_right_q <= step_toward(level_right_q, target_right,
                                   fine_step_select_q);
    end
  end

  // ==========================================================================
  // Gain, saturation and word formatting of the incoming sample
  logic [8:0] level_now;
  logic [15:0] gain_lin;
  logic signed [40:0] product;
  logic signed [40:0] scaled;
  logic [23:0] sat_sample;
  logic [23:0] narrow;
  logic [4:0] word_bits;
  logic [31:0] fill_word;
  assign level_now = sample_right ? level_right_q : level_left_q;
  assign gain_lin = level_to_gain(level_now);
  assign product = $signed(sample_data) * $signed({1'b0, gain_lin});
  assign scaled = product >>> GAIN_FRAC_BITS;

  always_comb begin
    if (level_now == LEVEL_MUTE) begin
      sat_sample = 24'h000000;
    end else if ((&scaled[40:23]) || !(|scaled[40:23])) begin
      sat_sample = scaled[23:0];
    end else if (scaled[40]) begin
      sat_sample = 24'h800000;
    end else begin
      sat_sample = 24'h7FFFFF;
    end
  end
  always_comb begin
    case (sample_width_q)
      2'h0: word_bits = 5'h10;
      2'h1: word_bits = 5'h12;
      2'h2: word_bits = 5'h14;
      default: word_bits = 5'h18;
    endcase
    narrow = 24'($signed(sat_sample) >>> (5'h18 - word_bits));
    fill_word = {{8{narrow[23]}}, narrow};
    if (!msb_fill_mode_q) begin
      fill_word = fill_word & ((32'h00000001 << word_bits) - 32'h00000001);
    end
  end

  // ==========================================================================
  // Receive FIFO
  logic [31:0] fifo_mem [0:255];
  logic [7:0] wr_ptr_q;
  logic [7:0] rd_ptr_q;
  logic [8:0] fifo_count_q;
  logic fifo_read;
  logic push;
  logic pop;
  logic overrun;
  logic underrun;
  assign fifo_read = dp_read_q && dp_addr_q == OFS_FIFO_READ;
  // Muted samples are pushed like any other
  assign push = sample_valid && fifo_count_q != FIFO_DEPTH;
  assign overrun = sample_valid && fifo_count_q == FIFO_DEPTH;
  assign pop = fifo_read && fifo_count_q != 9'h000;
  assign underrun = fifo_read && fifo_count_q == 9'h000;

  always_ff @(posedge hclk) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= fill_word;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q <= 8'h00;
      rd_ptr_q <= 8'h00;
      fifo_count_q <= 9'h000;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 8'h01;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 8'h01;
      end
      fifo_count_q <= fifo_count_q + 9'(push) - 9'(pop);
    end
  end

  // ==========================================================================
  // Events
  logic [EVT_COUNT-1:0] event_status_q;
  logic [EVT_COUNT-1:0] event_masked;
  logic [EVT_COUNT-1:0] hw_event;
  logic [EVT_COUNT-1:0] sw_set;
  logic [EVT_COUNT-1:0] sw_clear;
  always_comb begin
    hw_event = 4'h0;
    hw_event[EVT_LEVEL] = fifo_count_q > 9'(fifo_threshold_q);
    hw_event[EVT_HAS_DATA] = fifo_count_q != 9'h000;
    hw_event[EVT_OVERRUN] = overrun;
    hw_event[EVT_UNDERRUN] = underrun;
  end

  assign sw_set = (wr_en && dp_addr_q == OFS_EVENT_SET) ?
                  hwdata[EVT_COUNT-1:0] : 4'h0;
  assign sw_clear = (wr_en && dp_addr_q == OFS_EVENT_STATUS) ?
                    hwdata[EVT_COUNT-1:0] : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_status_q <= 4'h0;
    end else begin
      // Sticky; setting terms come last so they beat a clear
      event_status_q <= (event_status_q & ~sw_clear) |
                        hw_event | sw_set;
    end
  end

  assign event_masked = event_status_q & event_enable_q;
  assign converter_irq = |event_masked;

  // ==========================================================================
  // Read data, latched during the wait state
  always_comb begin
    case (dp_addr_q)
      OFS_CONVERTER_CONTROL: rd_value = {22'h000000, soft_mute_ctl_q,
        fine_step_select_q, gain_right_q, gain_left_q};
      OFS_MODE_CONTROL: rd_value = {30'h00000000, step_interval_q};
      OFS_DATA_FORMAT: rd_value = {29'h0, msb_fill_mode_q, sample_width_q};
      OFS_FIFO_CONTROL: rd_value = {24'h000000, fifo_threshold_q};
      OFS_EVENT_STATUS: rd_value = {28'h0000000, event_status_q};
      OFS_EVENT_ENABLE: rd_value = {28'h0000000, event_enable_q};
      OFS_EVENT_MASKED: rd_value = {28'h0000000, event_masked};
      OFS_FIFO_READ: rd_value = pop ? fifo_mem[rd_ptr_q] : 32'h00000000;
      OFS_FIFO_LEVEL: rd_value = {23'h000000, fifo_count_q};
      default: rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (dp_read_q) begin
      hrdata_q <= rd_value;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_irq_masked_or: assert property (
    converter_irq == |(event_status_q & event_enable_q))
    else $error("interrupt differs from OR of masked events");
  a_status_sticky: assert property (
    (event_status_q[EVT_OVERRUN] && !sw_clear[EVT_OVERRUN])
      |=> event_status_q[EVT_OVERRUN])
    else $error("overrun status dropped without a clear");
  a_overrun_flag: assert property (
    overrun |=> event_status_q[EVT_OVERRUN])
    else $error("overrun did not set status");
  a_overrun_drop: assert property (
    (fifo_count_q == FIFO_DEPTH && sample_valid && !pop)
      |=> fifo_count_q == FIFO_DEPTH && $stable(wr_ptr_q))
    else $error("sample written into a full FIFO");
  a_underrun_flag: assert property (
    (fifo_read && fifo_count_q == 9'h000) |=> event_status_q[EVT_UNDERRUN])
    else $error("empty read did not set underrun");
  a_level_flag: assert property (
    (fifo_count_q > 9'(fifo_threshold_q)) |=> event_status_q[EVT_LEVEL])
    else $error("level event missing above threshold");
  a_data_flag: assert property (
    (fifo_count_q != 9'h000) |=> event_status_q[EVT_HAS_DATA])
    else $error("data event missing with FIFO not empty");
  // Any bit, so the level-type events that the bench clears also reach it
  a_set_wins: assert property (
    (|(hw_event & sw_clear))
      |=> &(event_status_q | ~$past(hw_event & sw_clear)))
    else $error("clear beat a same-cycle event");
  a_soft_set: assert property (
    sw_set[EVT_UNDERRUN] |=> event_status_q[EVT_UNDERRUN])
    else $error("software set had no effect");
  a_fine_step: assert property (
    step_en |=> (level_left_q - $past(level_left_q) <= 9'h002) ||
                ($past(level_left_q) - level_left_q <= 9'h002))
    else $error("gain moved by more than one fine step");
  a_step_hold: assert property (
    !step_en |=> $stable(level_left_q) && $stable(level_right_q))
    else $error("gain moved outside the step interval");
  a_mute_stream: assert property (
    (push && !pop) |=> fifo_count_q == $past(fifo_count_q) + 9'h001)
    else $error("sample not stored");
  a_zero_fill: assert property (
    (push && !msb_fill_mode_q && sample_width_q == 2'h0)
      |-> fill_word[31:16] == 16'h0000)
    else $error("upper bits not zero filled");
  c_overrun: cover property (overrun ##1 converter_irq);
  c_underrun: cover property (underrun);
  c_mute_floor: cover property (soft_mute_ctl_q && level_left_q == LEVEL_MUTE);
  c_set_vs_clear: cover property (overrun && sw_clear[EVT_OVERRUN]);

endmodule : pcm_gain_mute_and_event_logic

// file: pcm_gain_pkg.sv
// Register map, field layout, reset values and constants of the PCM output logic
package pcm_gain_pkg;

  // ==========================================================================
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_CONVERTER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE_CONTROL = 8'h04;
  localparam logic [7:0] OFS_DATA_FORMAT = 8'h08;
  localparam logic [7:0] OFS_FIFO_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVENT_SET = 8'h14;
  localparam logic [7:0] OFS_EVENT_ENABLE = 8'h18;
  localparam logic [7:0] OFS_EVENT_MASKED = 8'h1C;
  localparam logic [7:0] OFS_FIFO_READ = 8'h20;
  localparam logic [7:0] OFS_FIFO_LEVEL = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int GAIN_LEFT_LSB = 0;
  localparam int GAIN_RIGHT_LSB = 4;
  localparam int FINE_STEP_BIT = 8;
  localparam int SOFT_MUTE_BIT = 9;
  localparam int STEP_INTERVAL_LSB = 0;
  localparam int SAMPLE_WIDTH_LSB = 0;
  localparam int MSB_FILL_BIT = 2;
  localparam int THRESHOLD_LSB = 0;

  // Event bit positions
  localparam int EVT_LEVEL = 0;
  localparam int EVT_HAS_DATA = 1;
  localparam int EVT_OVERRUN = 2;
  localparam int EVT_UNDERRUN = 3;
  localparam int EVT_COUNT = 4;

  // ==========================================================================
  // Reset values
  localparam logic [3:0] GAIN_RESET = 4'h8;
  localparam logic [1:0] STEP_INTERVAL_RESET = 2'h0;
  localparam logic [1:0] SAMPLE_WIDTH_RESET = 2'h3;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;

  // ==========================================================================
  // FIFO, gain and smoother constants
  localparam logic [8:0] FIFO_DEPTH = 9'h100;
  localparam logic [9:0] INTERVAL_BASE = 10'h040;
  localparam logic [8:0] LEVEL_MUTE = 9'h000;
  localparam logic [8:0] TARGET_BASE = 9'h058;
  localparam logic [8:0] CODE_STEP_X2 = 9'h017;
  localparam logic [8:0] UNITS_PER_OCTAVE = 9'h02E;
  localparam logic [15:0] MANT_ONE = 16'h0100;
  localparam logic [15:0] MANT_SLOPE_X16 = 16'h0059;
  localparam int GAIN_FRAC_BITS = 12;

endpackage : pcm_gain_pkg

// file: pcm_source_model.sv
// Sample and sample-period source standing in for the converter front end
`timescale 1ns/100ps
module pcm_source_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic stereo,
  input wire logic [9:0] count,
  input wire logic [23:0] data,
  input wire logic [15:0] ticks,
  output logic busy,
  output logic sample_valid,
  output logic sample_right,
  output logic [23:0] sample_data,
  output logic sample_period_tick
);
  // ==========================================================================
  // Burst and tick counters
  logic [9:0] left_q;
  logic [15:0] tick_q;
  logic [23:0] data_q;
  logic phase_q;
  logic stereo_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_q <= 10'h000;
      tick_q <= 16'h0000;
      data_q <= 24'h000000;
      phase_q <= 1'b0;
      stereo_q <= 1'b0;
      sample_right <= 1'b0;
    end else if (go) begin
      left_q <= count;
      tick_q <= ticks;
      data_q <= data;
      stereo_q <= stereo;
      sample_right <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      if (sample_valid) begin
        left_q <= left_q - 10'h001;
        sample_right <= stereo_q & ~sample_right;
      end
      if (tick_q != 16'h0000) begin
        phase_q <= ~phase_q;
        if (phase_q) begin
          tick_q <= tick_q - 16'h0001;
        end
      end
    end
  end

  assign sample_valid = left_q != 10'h000;
  // Idle data shows the inverse, so a stale word never passes for a sample
  assign sample_data = sample_valid ? data_q : ~data_q;
  // Tick is a one-cycle pulse every other cycle, never a standing level
  assign sample_period_tick = (tick_q != 16'h0000) && phase_q;
  assign busy = sample_valid || (tick_q != 16'h0000);
endmodule : pcm_source_model

// file: tb_top.sv
// Self-checking bench for the PCM gain, mute and event logic
`timescale 1ns/100ps
module tb_top
  import pcm_gain_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v, lv, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sample_valid, sample_right, sample_period_tick, converter_irq;
  logic [23:0] sample_data, dat;
  logic go, stereo, busy;
  logic [9:0] cnt;
  logic [15:0] ticks;
  int errors, check_count, wd;

  always #50 hclk = ~hclk;

  pcm_gain_mute_and_event_logic i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sample_valid(sample_valid), .sample_right(sample_right),
    .sample_data(sample_data), .sample_period_tick(sample_period_tick),
    .converter_irq(converter_irq));

  pcm_source_model i_src (.hclk(hclk), .hresetn(hresetn), .go(go),
    .stereo(stereo), .count(cnt), .data(dat), .ticks(ticks), .busy(busy),
    .sample_valid(sample_valid), .sample_right(sample_right),
    .sample_data(sample_data), .sample_period_tick(sample_period_tick));

  // ==========================================================================
  // Reporting
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic fail_out();
    errors++;
    report_and_stop();
  endtask : fail_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  // ==========================================================================
  // AHB-Lite master
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) fail_out();
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wdat, output logic [31:0] rdat);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wdat;
    wait_rdy();
    rdat = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h00000000, x);
    chk(x, e);
    chk({31'h0, hresp}, 32'h00000000);
  endtask : rd_chk

  task automatic irq_chk(input logic e);
    @(posedge hclk);
    chk({31'h0, converter_irq}, {31'h0, e});
  endtask : irq_chk

  task automatic drain(input int n);
    logic [31:0] x;
    for (int i = 0; i < n; i++) begin
      xfer(1'b0, OFS_FIFO_READ, 32'h00000000, x);
    end
  endtask : drain

  // ==========================================================================
  // Sample source control
  task automatic push(input logic [9:0] n, input logic [23:0] d,
                      input logic st, input logic [15:0] t);
    int k;
    go <= 1'b1;
    cnt <= n;
    dat <= d;
    stereo <= st;
    ticks <= t;
    @(posedge hclk);
    go <= 1'b0;
    k = 0;
    @(posedge hclk);
    while (busy !== 1'b0) begin
      k++;
      if (k > 20000) fail_out();
      @(posedge hclk);
    end
    @(posedge hclk);
  endtask : push

  // ==========================================================================
  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    go = 1'b0;
    stereo = 1'b0;
    cnt = 10'h000;
    dat = 24'h000000;
    ticks = 16'h0000;
    errors = 0;
    check_count = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(OFS_CONVERTER_CONTROL, 32'h00000088);
    rd_chk(OFS_DATA_FORMAT, 32'h00000003);
    rd_chk(OFS_FIFO_CONTROL, 32'h00000000);
    rd_chk(OFS_EVENT_STATUS, 32'h00000000);
    rd_chk(OFS_EVENT_MASKED, 32'h00000000);
    rd_chk(OFS_FIFO_LEVEL, 32'h00000000);
    wr(8'h30, 32'hFFFFFFFF);
    rd_chk(8'h30, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MODE_CONTROL, 32'(i));
      rd_chk(OFS_MODE_CONTROL, 32'(i));
    end
    wr(OFS_MODE_CONTROL, 32'h00000000);
    done("registers");
    wr(OFS_EVENT_SET, 32'h0000000F);
    rd_chk(OFS_EVENT_STATUS, 32'h0000000F);
    rd_chk(OFS_EVENT_MASKED, 32'h00000000);
    irq_chk(1'b0);
    wr(OFS_EVENT_ENABLE, 32'h00000006);
    rd_chk(OFS_EVENT_ENABLE, 32'h00000006);
    rd_chk(OFS_EVENT_SET, 32'h00000000);
    irq_chk(1'b1);
    xfer(1'b0, OFS_EVENT_MASKED, 32'h00000000, v);
    chk(v, 32'h00000006);
    wr(OFS_EVENT_STATUS, v);
    rd_chk(OFS_EVENT_STATUS, 32'h00000009);
    irq_chk(1'b0);
    wr(OFS_EVENT_STATUS, 32'h00000009);
    rd_chk(OFS_FIFO_READ, 32'h00000000);
    rd_chk(OFS_EVENT_STATUS, 32'h00000008);
    irq_chk(1'b0);
    wr(OFS_EVENT_STATUS, 32'h00000008);
    done("events");
    wr(OFS_FIFO_CONTROL, 32'h00000002);
    push(10'd2, 24'h000100, 1'b0, 16'h0000);
    rd_chk(OFS_EVENT_STATUS, 32'h00000002);
    push(10'd1, 24'h000100, 1'b0, 16'h0000);
    rd_chk(OFS_FIFO_LEVEL, 32'h00000003);
    rd_chk(OFS_EVENT_STATUS, 32'h00000003);
    wr(OFS_EVENT_STATUS, 32'h00000003);
    rd_chk(OFS_EVENT_STATUS, 32'h00000003);
    irq_chk(1'b1);
    drain(3);
    wr(OFS_EVENT_STATUS, 32'h00000003);
    rd_chk(OFS_EVENT_STATUS, 32'h00000000);
    done("threshold");
    for (int w = 0; w < 4; w++) begin
      for (int f = 0; f < 2; f++) begin
        wr(OFS_DATA_FORMAT, 32'((f << MSB_FILL_BIT) | w));
        push(10'd1, 24'h800000, 1'b0, 16'h0000);
        xfer(1'b0, OFS_FIFO_READ, 32'h00000000, v);
        // Width code 3 selects 24 bits, not 22
        wd = (w == 3) ? 24 : 16 + 2 * w;
        chk(v >> wd, (f == 1) ? 32'hFFFFFFFF >> wd : 32'h0);
        chk({31'h0, v[wd-1]}, 32'h00000001);
      end
    end
    wr(OFS_DATA_FORMAT, 32'h00000003);
    wr(OFS_EVENT_STATUS, 32'h0000000F);
    done("format");
    // Left at top code, right at bottom code, mute ramp in 0.13 dB steps
    wr(OFS_CONVERTER_CONTROL, 32'h0000020F);
    rd_chk(OFS_CONVERTER_CONTROL, 32'h0000020F);
    push(10'd0, 24'h000000, 1'b0, 16'd6000);
    push(10'd2, 24'h100000, 1'b1, 16'h0000);
    rd_chk(OFS_FIFO_LEVEL, 32'h00000002);
    rd_chk(OFS_FIFO_READ, 32'h00000000);
    rd_chk(OFS_FIFO_READ, 32'h00000000);
    wr(OFS_CONVERTER_CONTROL, 32'h0000010F);
    push(10'd1, 24'h100000, 1'b0, 16'h0000);
    rd_chk(OFS_FIFO_READ, 32'h00000000);
    push(10'd0, 24'h000000, 1'b0, 16'd9000);
    push(10'd2, 24'h100000, 1'b1, 16'h0000);
    xfer(1'b0, OFS_FIFO_READ, 32'h00000000, lv);
    xfer(1'b0, OFS_FIFO_READ, 32'h00000000, rv);
    chk({31'h0, lv > rv}, 32'h00000001);
    chk({31'h0, rv != 32'h0}, 32'h00000001);
    wr(OFS_EVENT_STATUS, 32'h0000000F);
    done("gain_mute");
    push(10'd257, 24'h000001, 1'b0, 16'h0000);
    rd_chk(OFS_FIFO_LEVEL, 32'h00000100);
    xfer(1'b0, OFS_EVENT_STATUS, 32'h00000000, v);
    chk(v & 32'h4, 32'h00000004);
    drain(1);
    rd_chk(OFS_FIFO_LEVEL, 32'h000000FF);
    xfer(1'b0, OFS_EVENT_STATUS, 32'h00000000, v);
    chk(v & 32'h4, 32'h00000004);
    drain(255);
    wr(OFS_EVENT_STATUS, 32'h0000000F);
    rd_chk(OFS_EVENT_STATUS, 32'h00000000);
    done("overrun");
    report_and_stop();
  end
endmodule : tb_top
